// ### src/mseq_pkg.sv
package mseq_pkg;

  // Microword layout
  localparam int MW_WIDTH    = 36;
  localparam int OUT_WIDTH   = 16;
  localparam int ADDR_WIDTH  = 8;
  localparam int OPC_WIDTH   = 3;
  localparam int COND_WIDTH  = 8;

  typedef struct packed {
    logic                  oe_field;
    logic [OPC_WIDTH-1:0]  opcode_field;
    logic [ADDR_WIDTH-1:0] const_field;
    logic [ADDR_WIDTH-1:0] next_field;
    logic [OUT_WIDTH-1:0]  out_field;
  } mseq_word_t;

  // Memory organisation
  localparam int             MEM_WORDS   = 448;
  localparam int             MEM_IDX_W   = 9;
  localparam logic [7:0]     MULTI_BASE  = 8'hc0;
  localparam int             MULTI_LOCS  = 64;
  localparam int             SUB_WORDS   = 4;
  localparam int             CONDS       = 3;
  localparam int             TERMS       = 4;
  localparam int             PTERM_COUNT = 768;
  localparam int             PTERM_IDX_W = 10;
  localparam int             STACK_DEPTH = 15;
  localparam int             DEPTH_W     = 4;

  // Product term: enable, care mask, compare value
  typedef struct packed {
    logic                  en;
    logic [COND_WIDTH-1:0] mask;
    logic [COND_WIDTH-1:0] value;
  } mseq_pterm_t;

  typedef enum logic [OPC_WIDTH-1:0] {
    OPC_NEXT, OPC_JUMP, OPC_RET, OPC_CALL, OPC_LOADC, OPC_LOOPNZ, OPC_PUSHD, OPC_POPC
  } mseq_opc_t;

  // Reset pin
  localparam logic [1:0] RST_MIN_EDGES = 2'h3;

  // Avalon-MM register map (byte addresses)
  localparam int         BUS_ADDR_W = 6;
  localparam logic [5:0] REG_CTRL       = 6'h00;
  localparam logic [5:0] REG_STATUS     = 6'h04;
  localparam logic [5:0] REG_PROG_IDX   = 6'h08;
  localparam logic [5:0] REG_PROG_LO    = 6'h0c;
  localparam logic [5:0] REG_PROG_HI    = 6'h10;
  localparam logic [5:0] REG_PTERM_IDX  = 6'h14;
  localparam logic [5:0] REG_PTERM_DATA = 6'h18;
  localparam logic [5:0] REG_PIPE       = 6'h1c;

  // Field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int ST_CNT_LSB     = 8;
  localparam int ST_ZERO_BIT    = 16;
  localparam int ST_DEPTH_LSB   = 17;
  localparam int ST_RUN_BIT     = 21;
  localparam int PROG_HI_W      = 4;

endpackage

// ### src/mseq_core.sv
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module mseq_core
  import mseq_pkg::*;
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  // Master reset pin
  input  wire logic                          master_reset_n,
  // User side
  input  wire logic [mseq_pkg::COND_WIDTH-1:0] cond_in,
  output logic      [mseq_pkg::OUT_WIDTH-1:0]  user_out,
  output logic      [mseq_pkg::OUT_WIDTH-1:0]  user_out_oe,
  // Avalon-MM slave
  input  wire logic [mseq_pkg::BUS_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest
);
  import mseq_pkg::*;

  function automatic logic [MEM_IDX_W-1:0] mem_index(input logic [7:0] a, input logic [1:0] s);
    logic [MEM_IDX_W-1:0] off;
    off = {3'h0, 6'(a - MULTI_BASE)};
    if (a < MULTI_BASE)
      return {1'b0, a};
    return {1'b0, MULTI_BASE} + (off << 2) + {7'h00, s};
  endfunction

  function automatic logic pterm_hit(input mseq_pterm_t p, input logic [7:0] c);
    return p.en && (((c ^ p.value) & p.mask) == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  mseq_word_t  mem_array [MEM_WORDS];
  mseq_pterm_t pterm_array [PTERM_COUNT];
  logic [ADDR_WIDTH-1:0] stack_array [STACK_DEPTH];

  mseq_word_t            pipe_reg;
  logic [ADDR_WIDTH-1:0] cur_addr_reg;
  logic [MEM_IDX_W-1:0]  cur_idx_reg;
  logic [ADDR_WIDTH-1:0] cnt_reg;
  logic [DEPTH_W-1:0]    depth_reg;
  logic                  run_reg;
  logic [MEM_IDX_W-1:0]  prog_idx_reg;
  logic [31:0]           prog_lo_reg;
  logic [PTERM_IDX_W-1:0] pterm_idx_reg;
  logic                  ack_reg;
  logic [31:0]           rdata_reg;
  logic [2:0]            mrst_sync_reg;
  logic [1:0]            low_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin: three flip-flops, a level counts once stages two and three agree

  wire pin_low   = !mrst_sync_reg[1] && !mrst_sync_reg[2];
  wire pin_high  = mrst_sync_reg[1] && mrst_sync_reg[2];
  wire mrst_hold = (low_cnt_reg == RST_MIN_EDGES);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mrst_sync_reg <= 3'h7;
      low_cnt_reg   <= 2'h0;
    end
    else
    begin
      mrst_sync_reg <= {mrst_sync_reg[1:0], master_reset_n};
      if (pin_high)
        low_cnt_reg <= 2'h0;
      else if (pin_low && !mrst_hold)
        low_cnt_reg <= low_cnt_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address multiplexer

  mseq_opc_t opc;
  assign opc = mseq_opc_t'(pipe_reg.opcode_field);

  wire                  cnt_zero = (cnt_reg == 8'h00);
  wire [ADDR_WIDTH-1:0] tos      = (depth_reg == 4'h0) ? 8'h00 : stack_array[depth_reg - 4'h1];

  logic [ADDR_WIDTH-1:0] next_addr;
  logic                  do_push;
  logic                  do_pop;
  logic [ADDR_WIDTH-1:0] push_val;

  always_comb
  begin
    next_addr = pipe_reg.next_field;
    do_push   = 1'b0;
    do_pop    = 1'b0;
    push_val  = pipe_reg.const_field;
    unique case (opc)
      OPC_NEXT:   next_addr = pipe_reg.next_field;
      OPC_JUMP:   next_addr = pipe_reg.const_field;
      OPC_RET:
      begin
        next_addr = tos;
        do_pop    = 1'b1;
      end
      OPC_CALL:
      begin
        next_addr = pipe_reg.const_field;
        do_push   = 1'b1;
        push_val  = pipe_reg.next_field;
      end
      OPC_LOADC:  next_addr = pipe_reg.next_field;
      OPC_LOOPNZ: next_addr = cnt_zero ? pipe_reg.next_field : pipe_reg.const_field;
      OPC_PUSHD:  do_push = 1'b1;
      OPC_POPC:   do_pop  = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch select: three prioritised conditions of four product terms each

  wire       in_multi = (next_addr >= MULTI_BASE);
  wire [5:0] loc      = 6'(next_addr - MULTI_BASE);
  logic [CONDS-1:0] cond_hit;

  for (genvar k = 0; k < CONDS; k++)
  begin : g_cond
    logic [TERMS-1:0] term_hit;
    for (genvar t = 0; t < TERMS; t++)
    begin : g_term
      wire [PTERM_IDX_W-1:0] pidx =
        PTERM_IDX_W'((32'(loc) * CONDS + k) * TERMS + t);
      assign term_hit[t] = pterm_hit(pterm_array[pidx], cond_in);
    end
    assign cond_hit[k] = |term_hit;
  end

  // Gated off below the multiway range so condition inputs cannot disturb it
  wire [1:0] branch_sel = !in_multi    ? 2'h0 :
                          cond_hit[2]  ? 2'h3 :
                          cond_hit[1]  ? 2'h2 :
                          cond_hit[0]  ? 2'h1 : 2'h0;

  wire [MEM_IDX_W-1:0] sel_idx  = mem_index(next_addr, branch_sel);
  mseq_word_t          sel_word;
  assign sel_word = mem_array[sel_idx];

  wire advance = run_reg && !mrst_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline, counter and stack

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pipe_reg     <= '0;
      cur_addr_reg <= 8'h00;
      cur_idx_reg  <= 9'h000;
    end
    else if (mrst_hold)
    begin
      pipe_reg     <= mem_array[0];
      cur_addr_reg <= 8'h00;
      cur_idx_reg  <= 9'h000;
    end
    else if (advance)
    begin
      pipe_reg     <= sel_word;
      cur_addr_reg <= next_addr;
      cur_idx_reg  <= sel_idx;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || mrst_hold)
      cnt_reg <= 8'h00;
    else if (advance)
    begin
      if (opc == OPC_LOADC)
        cnt_reg <= pipe_reg.const_field;
      else if (opc == OPC_POPC)
        cnt_reg <= tos;
      else if (opc == OPC_LOOPNZ && !cnt_zero)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // A push onto a full stack overwrites the top; a pop of an empty one yields zero
  wire                 stack_full = (depth_reg == DEPTH_W'(STACK_DEPTH));
  wire [DEPTH_W-1:0]   push_slot  = stack_full ? depth_reg - 4'h1 : depth_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset || mrst_hold)
      depth_reg <= 4'h0;
    else if (advance)
    begin
      if (do_push && !stack_full)
        depth_reg <= depth_reg + 4'h1;
      else if (do_pop && depth_reg != 4'h0)
        depth_reg <= depth_reg - 4'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (advance && do_push)
      stack_array[push_slot] <= push_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign user_out    = pipe_reg.out_field;
  assign user_out_oe = {OUT_WIDTH{pipe_reg.oe_field}};

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle per access

  wire   access   = avs_read || avs_write;
  wire   wr_take  = avs_write && ack_reg;
  assign avs_waitrequest = access && !ack_reg;
  assign avs_readdata    = rdata_reg;

  wire [31:0] status_word = {10'h000, run_reg, depth_reg, cnt_zero, cnt_reg, cur_addr_reg};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      REG_CTRL:       rd_mux = {31'h0, run_reg};
      REG_STATUS:     rd_mux = status_word;
      REG_PROG_IDX:   rd_mux = {23'h0, prog_idx_reg};
      REG_PROG_LO:    rd_mux = prog_lo_reg;
      REG_PTERM_IDX:  rd_mux = {22'h0, pterm_idx_reg};
      REG_PIPE:       rd_mux = pipe_reg[31:0];
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg   <= access && !ack_reg;
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      run_reg       <= 1'b0;
      prog_idx_reg  <= 9'h000;
      prog_lo_reg   <= 32'h0000_0000;
      pterm_idx_reg <= 10'h000;
    end
    else if (wr_take)
    begin
      if (avs_address == REG_CTRL)
        run_reg <= avs_writedata[CTRL_RUN_BIT];
      if (avs_address == REG_PROG_IDX)
        prog_idx_reg <= avs_writedata[MEM_IDX_W-1:0];
      if (avs_address == REG_PROG_LO)
        prog_lo_reg <= avs_writedata;
      if (avs_address == REG_PTERM_IDX)
        pterm_idx_reg <= avs_writedata[PTERM_IDX_W-1:0];
    end
  end

  // Rewriting the store while running is allowed but may race the next fetch
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
        mem_array[i] <= '0;
      for (int j = 0; j < PTERM_COUNT; j++)
        pterm_array[j] <= '0;
    end
    else if (wr_take)
    begin
      if (avs_address == REG_PROG_HI && prog_idx_reg < MEM_IDX_W'(MEM_WORDS))
        mem_array[prog_idx_reg] <= {avs_writedata[PROG_HI_W-1:0], prog_lo_reg};
      if (avs_address == REG_PTERM_DATA && pterm_idx_reg < PTERM_IDX_W'(PTERM_COUNT))
        pterm_array[pterm_idx_reg] <= avs_writedata[16:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_load;
    advance |=> pipe_reg == $past(sel_word);
  endproperty
  a_load: assert property (p_load) else $error("pipeline did not load selected word");

  property p_out;
    advance ##1 !mrst_hold |-> user_out == $past(sel_word.out_field);
  endproperty
  a_out: assert property (p_out) else $error("outputs differ from loaded word");

  property p_oe;
    advance |=> user_out_oe == {OUT_WIDTH{$past(sel_word.oe_field)}};
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  property p_single;
    advance && !in_multi |=> cur_idx_reg == {1'b0, $past(next_addr)};
  endproperty
  a_single: assert property (p_single) else $error("single word address ignored");

  property p_top;
    advance && in_multi && cond_hit[2] |=> cur_idx_reg[1:0] == 2'h3;
  endproperty
  a_top: assert property (p_top) else $error("highest condition lost");

  property p_none;
    advance && in_multi && cond_hit == 3'h0 |=>
      cur_idx_reg == mem_index($past(next_addr), 2'h0);
  endproperty
  a_none: assert property (p_none) else $error("default sub-word not chosen");

  property p_loop;
    advance && opc == OPC_LOOPNZ && !cnt_zero |=>
      cnt_reg == $past(cnt_reg) - 8'h01 && cur_addr_reg == $past(pipe_reg.const_field);
  endproperty
  a_loop: assert property (p_loop) else $error("loop branch wrong");

  property p_ret;
    advance && opc == OPC_RET && depth_reg != 4'h0 |=> depth_reg == $past(depth_reg) - 4'h1;
  endproperty
  a_ret: assert property (p_ret) else $error("return did not pop");

  property p_mreset;
    pin_low [*3] ##1 pin_low |=> depth_reg == 4'h0 && cnt_reg == 8'h00 && cur_addr_reg == 8'h00;
  endproperty
  a_mreset: assert property (p_mreset) else $error("master reset incomplete");

  property p_depth;
    depth_reg <= DEPTH_W'(STACK_DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("stack overflow");

  c_multi: cover property (advance && in_multi && cond_hit[1] && !cond_hit[2]);
  c_full:  cover property (advance && stack_full && do_push);
  c_loop:  cover property (advance && opc == OPC_LOOPNZ && cnt_zero);
  c_mrst:  cover property (mrst_hold ##1 !mrst_hold);

endmodule

// ### tb/mseq_user_model.sv
`timescale 1ns/1ps
module mseq_user_model
  import mseq_pkg::*;
(
  // Clock
  input  wire logic                           core_clk,
  // Condition source
  input  wire logic [mseq_pkg::COND_WIDTH-1:0] cond_sel,
  output logic      [mseq_pkg::COND_WIDTH-1:0] cond_in,
  // Sequencer outputs and resolved pins
  input  wire logic [mseq_pkg::OUT_WIDTH-1:0]  user_out,
  input  wire logic [mseq_pkg::OUT_WIDTH-1:0]  user_out_oe,
  output wire       [mseq_pkg::OUT_WIDTH-1:0]  pins
);
  genvar i;

  initial cond_in = 8'h00;

  // Conditions move only just after an edge, so setup is never violated
  always @(posedge core_clk)
    cond_in <= cond_sel;

  ////////////////////////////////////////////////////////////////////////////
  // No pull on the pins: a floated bit reads as z, never as a stale level
  generate
    for (i = 0; i < OUT_WIDTH; i++)
    begin : g_pin
      assign pins[i] = user_out_oe[i] ? user_out[i] : 1'bz;
    end
  endgenerate
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import mseq_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  master_reset_n = 1'b1;
  logic [COND_WIDTH-1:0] cond_in;
  logic [COND_WIDTH-1:0] cond_sel = 8'h00;
  logic [OUT_WIDTH-1:0]  user_out;
  logic [OUT_WIDTH-1:0]  user_out_oe;
  logic [OUT_WIDTH-1:0]  held;
  wire  [OUT_WIDTH-1:0]  pins;
  logic [5:0]            avs_address = 6'h00;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic [31:0]           q;
  logic                  avs_waitrequest;
  logic [7:0]            cs [5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h04};
  logic [15:0]           sub [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h3};
  int                    n_fail = 0;
  int                    compares = 0;

  always #20 core_clk = ~core_clk;

  mseq_core dut_u (.core_clk, .reset, .master_reset_n, .cond_in, .user_out, .user_out_oe,
                   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
                   .avs_waitrequest);

  mseq_user_model user_u (.core_clk, .cond_sel, .cond_in, .user_out, .user_out_oe, .pins);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Request held until the edge at which waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      $display("unexpected at %0t: bus never answered", $time);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp, "read");
  endtask

  task automatic prog(input logic [31:0] idx, input mseq_word_t w);
    bus(1'b1, REG_PROG_IDX, idx);
    bus(1'b1, REG_PROG_LO, w[31:0]);
    bus(1'b1, REG_PROG_HI, {28'h0, w[35:32]});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic seen(input logic [15:0] o, input logic oe);
    chk({user_out_oe, user_out}, {{16{oe}}, o}, "outputs");
    chk({16'h0, pins}, {16'h0, oe ? o : 16'hzzzz}, "pins");
  endtask

  task automatic seek(input logic [15:0] o);
    int n;
    n = 0;
    while (user_out !== o && n < 30)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    step(1);
    seen(16'h0, 1'b0);
    rd(REG_STATUS, 32'h0001_0000);
    rd(REG_CTRL, 32'h0);
    bus(1'b1, 6'h24, 32'hffff_ffff);
    rd(6'h24, 32'h0);
    rd(REG_PROG_HI, 32'h0);
    // Main loop 0 -> 5 -> 1 -> 200.x -> 0, with a call and return inside
    prog(32'd0, '{1'b1, 3'h3, 8'h05, 8'h01, 16'h1111});
    prog(32'd5, '{1'b1, 3'h2, 8'h00, 8'h00, 16'h5555});
    prog(32'd1, '{1'b0, 3'h1, 8'hc8, 8'h00, 16'h2222});
    for (int s = 0; s < 4; s++)
      prog(32'(224 + s), '{1'b1, 3'h0, 8'h00, 8'h00, 16'ha0a0 + 16'(s)});
    // One product term per condition: condition k follows input bit k and picks sub-word k+1
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, REG_PTERM_IDX, 32'((24 + k) * 4));
      bus(1'b1, REG_PTERM_DATA, {15'h0, 1'b1, 8'h01 << k, 8'h01 << k});
    end
    bus(1'b1, REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      cond_sel <= cs[i];
      step(4);
      seek(16'h1111);
      seen(16'h1111, 1'b1);
      step(1);
      seen(16'h5555, 1'b1);
      step(1);
      seen(16'h2222, 1'b0);
      step(1);
      seen(16'ha0a0 + sub[i], 1'b1);
      step(1);
      seen(16'h1111, 1'b1);
    end
    // Stopping the sequencer freezes the current state
    bus(1'b1, REG_CTRL, 32'h0);
    step(1);
    held = user_out;
    step(5);
    chk({16'h0, user_out}, {16'h0, held}, "frozen");
    chk({16'h0, held}, {16'h0, 16'ha0a3}, "stop point");
    rd(REG_STATUS, 32'h0001_00c8);
    bus(1'b1, REG_CTRL, 32'h1);
    cond_sel <= 8'h07;
    step(6);
    // Low for eight edges, more than the six the pin needs
    master_reset_n <= 1'b0;
    step(8);
    seen(16'h1111, 1'b1);
    rd(REG_STATUS, 32'h0021_0000);
    step(3);
    seen(16'h1111, 1'b1);
    master_reset_n <= 1'b1;
    step(4);
    seek(16'h5555);
    seen(16'h5555, 1'b1);
    step(2);
    seen(16'ha0a3, 1'b1);
    // Counter load and a counted loop at one address
    bus(1'b1, REG_CTRL, 32'h0);
    prog(32'd0, '{1'b1, 3'h4, 8'h02, 8'h02, 16'h4444});
    prog(32'd2, '{1'b1, 3'h5, 8'h02, 8'h03, 16'h6666});
    prog(32'd3, '{1'b1, 3'h0, 8'h00, 8'h03, 16'h7777});
    bus(1'b1, REG_CTRL, 32'h1);
    seek(16'h6666);
    seen(16'h6666, 1'b1);
    step(2);
    seen(16'h6666, 1'b1);
    step(1);
    seen(16'h7777, 1'b1);
    rd(REG_STATUS, 32'h0021_0003);
    results;
  end
endmodule
